//--- dcec_top.sv
// Purpose: DMA channel event control with APB register access
// Assumes: IRQ lines on pclk; pattern match from async logic
// Notes: Transfer engine outside; this block issues start and abort pulses
// Notes on behaviour
// - Eight-bit abort selector; selected IRQ aborts transfer, sets abort flag
// - Eight-bit start selector; selected IRQ starts a transfer
// - Force bit written one starts a transfer now; reads zero
// - Abort bit written one aborts the transfer; reads zero
// - Pattern enable: match aborts and clears channel enable; else ignored
// - Start enable gates start IRQ; clear means no start
// - Abort enable gates abort IRQ; clear means no abort
// - Event control bits 31:24 and 2:0 read zero
//
// The APB interface to the registers and the address map were left to the implementer.
`include "dcec_consts.svh"
module dcec_top #(
  parameter int NUM_IRQ = 256
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`DCEC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Event sources
  input wire logic [NUM_IRQ-1:0] irq_lines,
  input wire logic pattern_match,
  input wire logic transfer_done,
  // Transfer engine controls
  output logic start_pulse,
  output logic abort_pulse,
  output logic channel_enable,
  output logic channel_busy,
  output logic channel_abort_flag
);
  import dcec_pkg::*;

  initial begin
    if (NUM_IRQ < 1 || NUM_IRQ > 256) begin
      $error("NUM_IRQ out of range");
    end
  end

  dcec_irq_type abort_irq_select;
  dcec_irq_type start_irq_select;
  logic pattern_abort_enable;
  logic start_irq_enable;
  logic abort_irq_enable;
  dcec_state_type state;
  dcec_state_type next_state;
  logic start_hit;
  logic abort_hit;
  logic pattern_sync;
  logic pattern_last;

  dcec_irq_match #(.NUM_IRQ(NUM_IRQ)) u_start_match (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .irq_lines(irq_lines),
    .select(start_irq_select),
    .hit(start_hit)
  );

  dcec_irq_match #(.NUM_IRQ(NUM_IRQ)) u_abort_match (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .irq_lines(irq_lines),
    .select(abort_irq_select),
    .hit(abort_hit)
  );

  dcec_sync u_pattern_sync (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .async_in(pattern_match),
    .sync_out(pattern_sync)
  );

  // APB decode; zero-wait slave, every access answered in its access phase
  wire apb_acc = psel && penable && clk_en;
  wire apb_wr = apb_acc && pwrite;
  wire hit_ev = paddr == `DCEC_OFF_EVCTL;
  wire hit_ch = paddr == `DCEC_OFF_CHCTL;
  wire hit_st = paddr == `DCEC_OFF_STATUS;
  wire mapped = hit_ev || hit_ch || hit_st;
  wire wr_ev = apb_wr && hit_ev;
  wire wr_ch = apb_wr && hit_ch;
  wire rd_st = apb_acc && !pwrite && hit_st;

  // Event qualification
  wire sw_force = wr_ev && pwdata[`DCEC_FORCE_BIT];
  wire sw_abort = wr_ev && pwdata[`DCEC_ABORT_BIT];
  wire irq_start = start_irq_enable && start_hit;
  wire irq_abort = abort_irq_enable && abort_hit;
  wire pat_rise = pattern_sync && !pattern_last;
  wire pat_abort = pattern_abort_enable && pat_rise && channel_enable;
  wire any_abort = sw_abort || irq_abort || pat_abort;
  wire any_start = (sw_force || irq_start) && channel_enable;
  // Abort overrides start in the same cycle
  wire go_start = any_start && !any_abort;

  always_comb begin
    next_state = state;
    unique case (state)
      DCEC_IDLE: begin
        if (go_start) begin
          next_state = DCEC_BUSY;
        end else if (channel_enable) begin
          next_state = DCEC_ARMED;
        end
      end
      DCEC_ARMED: begin
        if (go_start) begin
          next_state = DCEC_BUSY;
        end else if (!channel_enable) begin
          next_state = DCEC_IDLE;
        end
      end
      DCEC_BUSY: begin
        if (any_abort || transfer_done || !channel_enable) begin
          next_state = DCEC_IDLE;
        end
      end
      default: next_state = DCEC_IDLE;
    endcase
  end

  // Readback; unimplemented bits and self-clearing bits read zero
  wire [31:0] ev_read = {8'h00, abort_irq_select, start_irq_select,
                         2'b00, pattern_abort_enable, start_irq_enable,
                         abort_irq_enable, 3'b000};
  wire [31:0] ch_read = {31'h0, channel_enable};
  wire [31:0] st_read = {29'h0, 1'b0, channel_abort_flag, channel_busy};
  wire [31:0] next_prdata = hit_ev ? ev_read :
                            hit_ch ? ch_read :
                            hit_st ? st_read : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abort_irq_select <= `DCEC_SEL_RESET;
      start_irq_select <= `DCEC_SEL_RESET;
      pattern_abort_enable <= 1'b0;
      start_irq_enable <= 1'b0;
      abort_irq_enable <= 1'b0;
    end else if (wr_ev) begin
      abort_irq_select <= pwdata[`DCEC_ABORT_SEL_HI:`DCEC_ABORT_SEL_LO];
      start_irq_select <= pwdata[`DCEC_START_SEL_HI:`DCEC_START_SEL_LO];
      pattern_abort_enable <= pwdata[`DCEC_PATTERN_ABORT_ENABLE_BIT];
      start_irq_enable <= pwdata[`DCEC_START_IRQ_ENABLE_BIT];
      abort_irq_enable <= pwdata[`DCEC_ABORT_IRQ_ENABLE_BIT];
    end
  end

  // Pattern abort clearing enable beats a same-cycle software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_enable <= 1'b0;
    end else if (clk_en) begin
      if (pat_abort) begin
        channel_enable <= 1'b0;
      end else if (wr_ch) begin
        channel_enable <= pwdata[`DCEC_CHANNEL_ENABLE_BIT];
      end
    end
  end

  // Abort flag: set wins over a read-to-clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_abort_flag <= 1'b0;
    end else if (clk_en) begin
      if (irq_abort) begin
        channel_abort_flag <= 1'b1;
      end else if (rd_st) begin
        channel_abort_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= DCEC_IDLE;
      pattern_last <= 1'b0;
      start_pulse <= 1'b0;
      abort_pulse <= 1'b0;
      channel_busy <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      pattern_last <= pattern_sync;
      start_pulse <= go_start;
      abort_pulse <= any_abort && (state == DCEC_BUSY);
      channel_busy <= next_state == DCEC_BUSY;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  // Checks
  a_abort_beats_start: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && any_abort |=> !start_pulse)
    else $error("start issued alongside abort");
  a_force_starts: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && sw_force && channel_enable && !any_abort |=> start_pulse)
    else $error("force write did not start");
  a_irq_start_gated: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && start_hit && !start_irq_enable && !sw_force |=> !start_pulse)
    else $error("start irq not gated");
  a_irq_abort_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && irq_abort |=> channel_abort_flag)
    else $error("abort flag not set");
  a_abort_gated: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && abort_hit && !abort_irq_enable && !sw_abort && !pat_abort
    && state == DCEC_BUSY |=> !abort_pulse)
    else $error("abort irq not gated");
  a_pattern_clears: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && pat_abort |=> !channel_enable && !channel_busy)
    else $error("pattern abort did not clear enable");
  a_sw_abort_idle: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && sw_abort && state == DCEC_BUSY |=> abort_pulse && !channel_busy)
    else $error("software abort ignored");
  a_reserved_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready && !pslverr && $past(hit_ev) && !$past(pwrite)
    |-> prdata[31:24] == 8'h00 && prdata[2:0] == 3'b000
    && prdata[7:6] == 2'b00)
    else $error("reserved bits nonzero");
  a_start_sel_used: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && start_irq_enable && start_hit && channel_enable && !any_abort
    |=> start_pulse)
    else $error("selected start irq lost");
endmodule : dcec_top

//--- dcec_consts.svh
// Purpose: Offsets, field positions, reset values for channel event control
// Assumes: Included by bare name
// Notes: Byte addresses on a 32-bit APB word map
`ifndef DCEC_CONSTS_SVH
`define DCEC_CONSTS_SVH
`define DCEC_ADDR_W 4
`define DCEC_OFF_EVCTL 4'h0
`define DCEC_OFF_CHCTL 4'h4
`define DCEC_OFF_STATUS 4'h8
`define DCEC_ABORT_SEL_HI 23
`define DCEC_ABORT_SEL_LO 16
`define DCEC_START_SEL_HI 15
`define DCEC_START_SEL_LO 8
`define DCEC_FORCE_BIT 7
`define DCEC_ABORT_BIT 6
`define DCEC_PATTERN_ABORT_ENABLE_BIT 5
`define DCEC_START_IRQ_ENABLE_BIT 4
`define DCEC_ABORT_IRQ_ENABLE_BIT 3
`define DCEC_SEL_RESET 8'hFF
`define DCEC_CHANNEL_ENABLE_BIT 0
`define DCEC_ST_BUSY_BIT 0
`define DCEC_ST_ABORTF_BIT 1
`define DCEC_ST_STARTS_BIT 2
`endif

//--- dcec_pkg.sv
// Purpose: Types for channel event control
// Assumes: Nothing
// Notes: Two-bit channel state; IDLE and BUSY codes differ in both bits
package dcec_pkg;
  typedef enum logic [1:0] {
    DCEC_IDLE = 2'h0,
    DCEC_ARMED = 2'h1,
    DCEC_BUSY = 2'h3
  } dcec_state_type;
  typedef logic [7:0] dcec_irq_type;
endpackage : dcec_pkg

//--- dcec_sync.sv
// Purpose: Three-flop synchroniser with agreement filter
// Assumes: Input asynchronous to pclk
// Notes: First stage is read only by the second stage
module dcec_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Data
  input wire logic async_in,
  output logic sync_out
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      sync_out <= 1'b0;
    end else if (clk_en) begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        sync_out <= s3;
      end
    end
  end
endmodule : dcec_sync

//--- dcec_irq_match.sv
// Purpose: Rising-edge detect and selector match on the IRQ vector
// Assumes: irq_lines from the same clock domain
// Notes: One-cycle hit pulse per new request
module dcec_irq_match #(
  parameter int NUM_IRQ = 256
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Requests
  input wire logic [NUM_IRQ-1:0] irq_lines,
  input wire logic [7:0] select,
  output logic hit
);
  initial begin
    if (NUM_IRQ < 1 || NUM_IRQ > 256) begin
      $error("NUM_IRQ out of range");
    end
  end
  logic [NUM_IRQ-1:0] irq_last;
  wire [NUM_IRQ-1:0] irq_rise = irq_lines & ~irq_last;
  wire sel_ok = 32'(select) < NUM_IRQ;
  wire hit_now = sel_ok && irq_rise[select];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_last <= '0;
      hit <= 1'b0;
    end else if (clk_en) begin
      irq_last <= irq_lines;
      hit <= hit_now;
    end
  end
endmodule : dcec_irq_match

//--- dcec_irq_model.sv
// Purpose: Interrupt request fabric stand-in for one channel
// Assumes: Requests are levels on pclk
// Notes: One line per fire, high for one cycle so each fire is one rise
module dcec_irq_model (
  // Clock
  input wire logic pclk,
  // Bench request
  input wire logic fire,
  input wire logic [7:0] fire_num,
  // Request fabric
  output logic [255:0] irq_lines
);
  always_ff @(posedge pclk) begin
    irq_lines <= '0;
    if (fire) begin
      irq_lines[fire_num] <= 1'h1;
    end
  end
endmodule : dcec_irq_model

//--- dcec_tb.sv
// Purpose: Self-checking bench for channel event control
// Assumes: Bench plays processor, engine and pattern logic
// Notes: Pulses are counted by a monitor, then compared
`include "dcec_consts.svh"
`define CHK(nm, ex, gt) begin checked++; \
  if ((gt) !== (ex)) begin bad_count++; \
  $display("ERROR %s expected %h seen %h", nm, ex, gt); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0;
  logic pwrite = 0, pattern_match = 0, transfer_done = 0, fire = 0;
  logic [3:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [7:0] fire_num = 0;
  logic [255:0] irq_lines;
  logic pready, pslverr, err, start_pulse, abort_pulse;
  logic channel_enable, channel_busy, channel_abort_flag;
  int bad_count = 0, checked = 0, starts = 0, aborts = 0, s0, a0;
  dcec_top dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_lines(irq_lines),
    .pattern_match(pattern_match), .transfer_done(transfer_done),
    .start_pulse(start_pulse), .abort_pulse(abort_pulse),
    .channel_enable(channel_enable), .channel_busy(channel_busy),
    .channel_abort_flag(channel_abort_flag));
  dcec_irq_model irqs (.pclk(pclk), .fire(fire), .fire_num(fire_num),
    .irq_lines(irq_lines));
  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    if (start_pulse === 1'h1) starts++;
    if (abort_pulse === 1'h1) aborts++;
  end
  task test_done;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // Ends one idle edge later so back-to-back calls never double-drive
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    if (n == 20) begin bad_count++; test_done(); end
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask : bus
  function automatic logic [31:0] ev(logic [7:0] ab, st, lo);
    return {8'h00, ab, st, lo};
  endfunction : ev
  task mark; s0 = starts; a0 = aborts; endtask : mark
  task irq(input logic [7:0] num);
    mark();
    fire_num <= num; fire <= 1;
    @(posedge pclk);
    fire <= 0;
    repeat (6) @(posedge pclk);
  endtask : irq
  task done;
    transfer_done <= 1; @(posedge pclk);
    transfer_done <= 0; repeat (2) @(posedge pclk);
  endtask : done
  task force_start; bus(1, `DCEC_OFF_EVCTL, ev(8'h00, 8'hFF, 8'h80));
    repeat (2) @(posedge pclk); endtask : force_start
  task t_regs;
    bus(0, `DCEC_OFF_EVCTL, 0); `CHK("evctl rst", 32'h00FFFF00, rd)
    bus(1, `DCEC_OFF_EVCTL, 32'hFFA55AFF);
    bus(0, `DCEC_OFF_EVCTL, 0); `CHK("evctl rw", 32'h00A55A38, rd)
    bus(0, 4'hC, 32'h0); `CHK("unmapped", 1'h1, err)
  endtask : t_regs
  task t_soft;
    bus(1, `DCEC_OFF_CHCTL, 1); mark(); force_start();
    `CHK("force", s0 + 1, starts)
    `CHK("busy", 1'h1, channel_busy)
    bus(1, `DCEC_OFF_EVCTL, ev(8'h00, 8'hFF, 8'h40));
    repeat (2) @(posedge pclk); `CHK("abort", a0 + 1, aborts)
  endtask : t_soft
  task t_irq;
    bus(1, `DCEC_OFF_EVCTL, ev(8'h00, 8'hFF, 8'h10)); irq(8'hFF);
    `CHK("irq start", s0 + 1, starts)
    done(); bus(1, `DCEC_OFF_EVCTL, ev(8'h00, 8'hFF, 8'h00)); irq(8'hFF);
    `CHK("start off", s0, starts)
    force_start(); bus(1, `DCEC_OFF_EVCTL, ev(8'h00, 8'hFF, 8'h08));
    irq(8'h00); `CHK("irq abort", a0 + 1, aborts)
    `CHK("flag", 1'h1, channel_abort_flag)
    force_start(); bus(1, `DCEC_OFF_EVCTL, ev(8'h00, 8'hFF, 8'h00));
    irq(8'h00); `CHK("abort off", a0, aborts)
    `CHK("still busy", 1'h1, channel_busy)
    done(); bus(1, `DCEC_OFF_EVCTL, ev(8'h09, 8'h09, 8'h18)); irq(8'h09);
    `CHK("same start", s0, starts)
    `CHK("same idle", 1'h0, channel_busy)
  endtask : t_irq
  task t_pattern;
    force_start(); bus(1, `DCEC_OFF_EVCTL, ev(8'h00, 8'hFF, 8'h00));
    mark(); pattern_match <= 1; repeat (8) @(posedge pclk);
    `CHK("pat off", 1'h1, channel_enable)
    pattern_match <= 0; repeat (8) @(posedge pclk);
    bus(1, `DCEC_OFF_EVCTL, ev(8'h00, 8'hFF, 8'h20));
    pattern_match <= 1; repeat (8) @(posedge pclk);
    `CHK("pat abort", a0 + 1, aborts)
    `CHK("pat channel_enable", 1'h0, channel_enable)
    pattern_match <= 0;
  endtask : t_pattern
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_regs();
    t_soft();
    t_irq();
    t_pattern();
    test_done();
  end
endmodule : testbench
